// ==== verilog/ezcs_dev.sv ====
// Endpoint zero control/status logic of a full-speed function.
// Assumes one 100 MHz clock shared with the link and an APB3 master.
//
// The APB register port was left to the implementer.
`timescale 1ns/10ps
`include "ezcs_map.svh"

module ezcs_dev #(
  parameter int MAXP = `EZCS_MAXP
) (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        resetn_i,
  // APB slave
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [11:0] paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  // Interrupt
  output logic             irq_o,
  // Link
  ezcs_if.dev              link
);

  initial begin
    if (MAXP < 8 || MAXP > 127) begin
      $error("MAXP must lie in 8..127");
    end
  end

  localparam logic [6:0] MAXP_W = 7'(MAXP);

  typedef struct packed {
    logic                setup_end;
    logic                rx_wait;
    logic                force_stall;
    logic                last_data;
    logic                stall_sent;
    logic                tx_loaded;
    logic [6:0]          rx_cnt;
    logic [6:0]          tx_len;
    ezcs_pkg::ezcs_mode_t mode;
    logic                wait_ack;
    logic [3:0]          irq_stat;
    logic [3:0]          irq_mask;
    logic                irq;
    logic [31:0]         prdata;
    logic                pready;
    logic                pslverr;
    logic                rsp_vld;
    ezcs_pkg::ezcs_rsp_t rsp_kind;
    logic [6:0]          rsp_len;
  } ezcs_dev_state_t;

  ezcs_dev_state_t s_q;
  ezcs_dev_state_t s_d;

  logic       setup_ph;
  logic       access_ph;
  logic       addr_ok;
  logic [7:0] idx;

  assign setup_ph  = psel_i & ~penable_i & ~s_q.pready;
  assign access_ph = psel_i & penable_i & s_q.pready;
  assign addr_ok   = (paddr_i[11:10] == 2'h0) && (paddr_i[1:0] == 2'h0);
  assign idx       = paddr_i[9:2];

  always_comb begin
    logic [3:0] ev;
    logic [7:0] w;
    logic       wr_csr;
    ev = 4'h0;
    w = pwdata_i[7:0];
    wr_csr = access_ph & pwrite_i & addr_ok & (idx == `EZCS_IDX_CSR);
    s_d = s_q;
    s_d.pready = 1'b0;
    s_d.pslverr = 1'b0;
    s_d.rsp_vld = 1'b0;

    // Read data is captured in the setup cycle, no wait state
    if (setup_ph) begin
      s_d.pready = 1'b1;
      s_d.prdata = 32'h0;
      if (!addr_ok) begin
        s_d.pslverr = 1'b1;
      end else begin
        unique case (idx)
          `EZCS_IDX_CSR: s_d.prdata[7:0] = {2'h0, s_q.force_stall,
            s_q.setup_end, s_q.last_data, s_q.stall_sent,
            s_q.tx_loaded, s_q.rx_wait};
          `EZCS_IDX_CNT:
            s_d.prdata[6:0] = s_q.rx_wait ? s_q.rx_cnt : 7'h00;
          `EZCS_IDX_TXLEN:    s_d.prdata[6:0] = s_q.tx_len;
          `EZCS_IDX_IRQ_STAT: s_d.prdata[3:0] = s_q.irq_stat;
          `EZCS_IDX_IRQ_MASK: s_d.prdata[3:0] = s_q.irq_mask;
          default: s_d.pslverr = 1'b1;
        endcase
      end
    end

    // Firmware clears go first so that hardware sets win
    if (wr_csr) begin
      if (w[`EZCS_B_SETUP_END_ACK]) begin
        s_d.setup_end = 1'b0;
      end
      if (w[`EZCS_B_OUT_READY_ACK]) begin
        s_d.rx_wait = 1'b0;
      end
      if (!w[`EZCS_B_FORCE_STALL]) begin
        s_d.force_stall = 1'b0;
      end
      if (!w[`EZCS_B_STALL_SENT]) begin
        s_d.stall_sent = 1'b0;
      end
    end
    if (access_ph & pwrite_i & addr_ok) begin
      if (idx == `EZCS_IDX_TXLEN) begin
        s_d.tx_len = w[6:0];
      end
      if (idx == `EZCS_IDX_IRQ_MASK) begin
        s_d.irq_mask = w[3:0];
      end
    end
    // Clears exactly the bits that were returned
    if (access_ph & ~pwrite_i & addr_ok & (idx == `EZCS_IDX_IRQ_STAT)) begin
      s_d.irq_stat = s_q.irq_stat & ~s_q.prdata[3:0];
    end

    if (link.tok_vld) begin
      // Corrupt setup/out or misshapen setup packets stay unanswered even when stalling; any IN is stalled
      if (s_q.force_stall && (link.tok_kind == ezcs_pkg::TOK_IN
          || (link.tok_ok && (link.tok_kind == ezcs_pkg::TOK_OUT
          || (link.tok_kind == ezcs_pkg::TOK_SETUP
          && link.tok_len == `EZCS_SETUP_LEN))))) begin
        s_d.rsp_vld = 1'b1;
        s_d.rsp_kind = ezcs_pkg::RSP_STALL;
        s_d.rsp_len = 7'h00;
        s_d.force_stall = 1'b0;
        s_d.stall_sent = 1'b1;
        ev[`EZCS_EV_STALL] = 1'b1;
        s_d.mode = ezcs_pkg::MODE_IDLE;
        s_d.wait_ack = 1'b0;
      end else begin
        if (link.tok_kind != ezcs_pkg::TOK_ACK) begin
          s_d.wait_ack = 1'b0;
        end
        unique case (link.tok_kind)
          ezcs_pkg::TOK_SETUP: begin
            // Wrong-sized or corrupt setup gets no answer at all
            if (link.tok_ok && link.tok_len == `EZCS_SETUP_LEN) begin
              if (s_q.mode != ezcs_pkg::MODE_IDLE && !s_q.last_data) begin
                s_d.setup_end = 1'b1;
                ev[`EZCS_EV_SEND] = 1'b1;
              end
              if (s_q.tx_loaded) begin
                s_d.tx_loaded = 1'b0;
                ev[`EZCS_EV_TX] = 1'b1;
              end
              s_d.rx_wait = 1'b1;
              s_d.rx_cnt = link.tok_len;
              ev[`EZCS_EV_RX] = 1'b1;
              s_d.last_data = 1'b0;
              s_d.mode = ezcs_pkg::MODE_IDLE;
              s_d.rsp_vld = 1'b1;
              s_d.rsp_kind = ezcs_pkg::RSP_ACK;
              s_d.rsp_len = 7'h00;
            end
          end
          ezcs_pkg::TOK_OUT: begin
            if (s_q.mode == ezcs_pkg::MODE_TX) begin
              s_d.setup_end = 1'b1;
              ev[`EZCS_EV_SEND] = 1'b1;
              s_d.mode = ezcs_pkg::MODE_IDLE;
            end
            if (link.tok_ok) begin
              s_d.rsp_vld = 1'b1;
              s_d.rsp_len = 7'h00;
              if ((s_q.last_data && s_q.mode == ezcs_pkg::MODE_RX)
                  || link.tok_len > MAXP_W) begin
                s_d.rsp_kind = ezcs_pkg::RSP_STALL;
                s_d.stall_sent = 1'b1;
                ev[`EZCS_EV_STALL] = 1'b1;
                s_d.mode = ezcs_pkg::MODE_IDLE;
              end else if (s_q.rx_wait) begin
                // Buffer still owned by firmware
                s_d.rsp_kind = ezcs_pkg::RSP_NAK;
              end else begin
                s_d.rsp_kind = ezcs_pkg::RSP_ACK;
                s_d.rx_wait = 1'b1;
                s_d.rx_cnt = link.tok_len;
                ev[`EZCS_EV_RX] = 1'b1;
                if (s_q.tx_loaded) begin
                  s_d.tx_loaded = 1'b0;
                  ev[`EZCS_EV_TX] = 1'b1;
                end
                s_d.mode = (link.tok_len < MAXP_W) ? ezcs_pkg::MODE_IDLE
                                                   : ezcs_pkg::MODE_RX;
              end
            end
          end
          ezcs_pkg::TOK_IN: begin
            if (s_q.mode == ezcs_pkg::MODE_RX && !s_q.last_data) begin
              s_d.setup_end = 1'b1;
              ev[`EZCS_EV_SEND] = 1'b1;
              s_d.mode = ezcs_pkg::MODE_IDLE;
            end
            s_d.rsp_vld = 1'b1;
            s_d.rsp_len = 7'h00;
            if (s_q.tx_loaded) begin
              s_d.rsp_kind = ezcs_pkg::RSP_DATA;
              s_d.rsp_len = s_q.tx_len;
              s_d.wait_ack = 1'b1;
              s_d.mode = ezcs_pkg::MODE_TX;
            end else if (s_q.last_data) begin
              // Status stage after received data: zero-length reply
              s_d.rsp_kind = ezcs_pkg::RSP_DATA;
              s_d.wait_ack = 1'b1;
            end else begin
              s_d.rsp_kind = ezcs_pkg::RSP_NAK;
            end
          end
          ezcs_pkg::TOK_ACK: begin
            if (s_q.wait_ack) begin
              s_d.wait_ack = 1'b0;
              if (s_q.tx_loaded) begin
                s_d.tx_loaded = 1'b0;
                ev[`EZCS_EV_TX] = 1'b1;
              end
              if (s_q.last_data) begin
                s_d.last_data = 1'b0;
                s_d.mode = ezcs_pkg::MODE_IDLE;
              end
            end
          end
        endcase
      end
    end

    // Firmware sets come last; read-only flags take no write
    if (wr_csr) begin
      if (w[`EZCS_B_FORCE_STALL]) begin
        s_d.force_stall = 1'b1;
      end
      if (w[`EZCS_B_LAST_DATA]) begin
        s_d.last_data = 1'b1;
      end
      if (w[`EZCS_B_TX_LOADED]) begin
        s_d.tx_loaded = 1'b1;
      end
    end

    s_d.irq_stat = s_d.irq_stat | ev;
    s_d.irq = |(s_d.irq_stat & s_d.irq_mask);
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign prdata_o      = s_q.prdata;
  assign pready_o      = s_q.pready;
  assign pslverr_o     = s_q.pslverr;
  assign irq_o         = s_q.irq;
  assign link.rsp_vld  = s_q.rsp_vld;
  assign link.rsp_kind = s_q.rsp_kind;
  assign link.rsp_len  = s_q.rsp_len;

endmodule

// ==== verilog/ezcs_map.svh ====
// Register offsets and field positions of both link ends, and the device CSR reset value.
// Included by bare name; holds definitions only.
`ifndef EZCS_MAP_SVH
`define EZCS_MAP_SVH

// Device word indices; byte address is four times the index
`define EZCS_IDX_CSR      8'h11
`define EZCS_IDX_CNT      8'h16
`define EZCS_IDX_TXLEN    8'h17
`define EZCS_IDX_IRQ_STAT 8'h20
`define EZCS_IDX_IRQ_MASK 8'h21

// Control/status field positions
`define EZCS_B_SETUP_END_ACK 7
`define EZCS_B_OUT_READY_ACK 6
`define EZCS_B_FORCE_STALL   5
`define EZCS_B_SETUP_END     4
`define EZCS_B_LAST_DATA     3
`define EZCS_B_STALL_SENT    2
`define EZCS_B_TX_LOADED     1
`define EZCS_B_RX_WAITING    0
`define EZCS_CSR_RESET       8'h00

// Device interrupt status bits
`define EZCS_EV_RX    0
`define EZCS_EV_TX    1
`define EZCS_EV_STALL 2
`define EZCS_EV_SEND  3

// Host byte addresses
`define EZCS_H_CMD      12'h000
`define EZCS_H_STAT     12'h004
`define EZCS_H_IRQ_STAT 12'h008
`define EZCS_H_IRQ_MASK 12'h00C

// Host command fields
`define EZCS_C_KIND_LSB 0
`define EZCS_C_LEN_LSB  2
`define EZCS_C_OK       9

// Setup data field is eight bytes
`define EZCS_SETUP_LEN 7'h08
`define EZCS_MAXP      64
`define EZCS_H_TIMEOUT 16

`endif

// ==== verilog/ezcs_pkg.sv ====
// Types shared by both ends of the endpoint zero link.
package ezcs_pkg;
  typedef enum logic [1:0] {TOK_SETUP, TOK_OUT, TOK_IN, TOK_ACK} ezcs_tok_t;
  typedef enum logic [1:0] {RSP_ACK, RSP_NAK, RSP_STALL, RSP_DATA} ezcs_rsp_t;
  typedef enum logic [1:0] {MODE_IDLE, MODE_RX, MODE_TX} ezcs_mode_t;
endpackage

// ==== verilog/ezcs_if.sv ====
// Packet-level link between the USB host end and the endpoint zero end.
// Both ends share one clock; every signal is driven from a flip-flop.
`timescale 1ns/10ps
interface ezcs_if;
  logic                tok_vld;
  ezcs_pkg::ezcs_tok_t tok_kind;
  logic [6:0]          tok_len;
  logic                tok_ok;
  logic                rsp_vld;
  ezcs_pkg::ezcs_rsp_t rsp_kind;
  logic [6:0]          rsp_len;

  modport dev (input tok_vld, tok_kind, tok_len, tok_ok,
               output rsp_vld, rsp_kind, rsp_len);
  modport host (output tok_vld, tok_kind, tok_len, tok_ok,
                input rsp_vld, rsp_kind, rsp_len);
endinterface

// ==== verilog/ezcs_host.sv ====
// USB host end: issues one token per command and records the answer.
// Assumes the same clock as the device end and an APB3 master.
`timescale 1ns/10ps
`include "ezcs_map.svh"

module ezcs_host #(
  parameter int TIMEOUT = `EZCS_H_TIMEOUT
) (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        resetn_i,
  // APB slave
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [11:0] paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  // Interrupt
  output logic             irq_o,
  // Link
  ezcs_if.host             link
);

  initial begin
    if (TIMEOUT < 2 || TIMEOUT > 255) begin
      $error("TIMEOUT must lie in 2..255");
    end
  end

  localparam logic [7:0] TMO_W = 8'(TIMEOUT);

  typedef struct packed {
    logic                busy;
    logic [7:0]          timer;
    logic                tok_vld;
    ezcs_pkg::ezcs_tok_t tok_kind;
    logic [6:0]          tok_len;
    logic                tok_ok;
    logic                timed_out;
    ezcs_pkg::ezcs_rsp_t rsp_kind;
    logic [6:0]          rsp_len;
    logic [1:0]          irq_stat;
    logic [1:0]          irq_mask;
    logic                irq;
    logic [31:0]         prdata;
    logic                pready;
    logic                pslverr;
  } ezcs_host_state_t;

  ezcs_host_state_t s_q;
  ezcs_host_state_t s_d;

  logic setup_ph;
  logic access_ph;

  assign setup_ph  = psel_i & ~penable_i & ~s_q.pready;
  assign access_ph = psel_i & penable_i & s_q.pready;

  always_comb begin
    logic [1:0] ev;
    ev = 2'h0;
    s_d = s_q;
    s_d.pready = 1'b0;
    s_d.pslverr = 1'b0;
    s_d.tok_vld = 1'b0;

    if (setup_ph) begin
      s_d.pready = 1'b1;
      s_d.prdata = 32'h0;
      unique case (paddr_i)
        `EZCS_H_CMD: s_d.prdata = 32'h0;
        `EZCS_H_STAT: s_d.prdata[10:0] = {s_q.rsp_len, s_q.rsp_kind,
                                          s_q.timed_out, s_q.busy};
        `EZCS_H_IRQ_STAT: s_d.prdata[1:0] = s_q.irq_stat;
        `EZCS_H_IRQ_MASK: s_d.prdata[1:0] = s_q.irq_mask;
        default: s_d.pslverr = 1'b1;
      endcase
    end

    if (access_ph & pwrite_i) begin
      // A command while busy is dropped
      if (paddr_i == `EZCS_H_CMD && !s_q.busy) begin
        s_d.tok_vld = 1'b1;
        s_d.tok_kind = ezcs_pkg::ezcs_tok_t'(pwdata_i[`EZCS_C_KIND_LSB +: 2]);
        s_d.tok_len = pwdata_i[`EZCS_C_LEN_LSB +: 7];
        s_d.tok_ok = pwdata_i[`EZCS_C_OK];
        s_d.timed_out = 1'b0;
        s_d.timer = 8'h00;
        if (s_d.tok_kind == ezcs_pkg::TOK_ACK) begin
          ev[0] = 1'b1;
        end else begin
          s_d.busy = 1'b1;
        end
      end
      if (paddr_i == `EZCS_H_IRQ_MASK) begin
        s_d.irq_mask = pwdata_i[1:0];
      end
    end
    if (access_ph & ~pwrite_i & (paddr_i == `EZCS_H_IRQ_STAT)) begin
      s_d.irq_stat = s_q.irq_stat & ~s_q.prdata[1:0];
    end

    if (s_q.busy) begin
      if (link.rsp_vld) begin
        s_d.busy = 1'b0;
        s_d.rsp_kind = link.rsp_kind;
        s_d.rsp_len = link.rsp_len;
        ev[0] = 1'b1;
      end else if (s_q.timer == TMO_W - 8'h01) begin
        // Rejected packets are never answered
        s_d.busy = 1'b0;
        s_d.timed_out = 1'b1;
        ev[1] = 1'b1;
      end else begin
        s_d.timer = s_q.timer + 8'h01;
      end
    end

    s_d.irq_stat = s_d.irq_stat | ev;
    s_d.irq = |(s_d.irq_stat & s_d.irq_mask);
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign prdata_o      = s_q.prdata;
  assign pready_o      = s_q.pready;
  assign pslverr_o     = s_q.pslverr;
  assign irq_o         = s_q.irq;
  assign link.tok_vld  = s_q.tok_vld;
  assign link.tok_kind = s_q.tok_kind;
  assign link.tok_len  = s_q.tok_len;
  assign link.tok_ok   = s_q.tok_ok;

endmodule

// ==== verification/ezcs_monitor.sv ====
// Link checker: packet/handshake relations on the endpoint zero link.
// Assumes both ends share clk_i; sees only the interface signals.
`timescale 1ns/10ps
`include "ezcs_map.svh"
module ezcs_monitor #(
  parameter int MAXP = `EZCS_MAXP
) (
  // Clock and reset
  input wire logic                clk_i,
  input wire logic                resetn_i,
  // Link
  input wire logic                tok_vld,
  input wire ezcs_pkg::ezcs_tok_t tok_kind,
  input wire logic [6:0]          tok_len,
  input wire logic                tok_ok,
  input wire logic                rsp_vld,
  input wire ezcs_pkg::ezcs_rsp_t rsp_kind,
  input wire logic [6:0]          rsp_len
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  wire logic t_su  = tok_vld && tok_kind == ezcs_pkg::TOK_SETUP;
  wire logic t_out = tok_vld && tok_kind == ezcs_pkg::TOK_OUT;

  chk_rsp_needs_tok: assert property (rsp_vld |-> $past(tok_vld))
    else $error("response without a token");
  chk_ack_silent: assert property (
    tok_vld && tok_kind == ezcs_pkg::TOK_ACK |=> !rsp_vld)
    else $error("answer to host handshake");
  chk_bad_crc_silent: assert property (
    (t_su || t_out) && !tok_ok |=> !rsp_vld)
    else $error("answer to corrupt packet");
  chk_setup_len_silent: assert property (
    t_su && tok_ok && tok_len != 7'h08 |=> !rsp_vld)
    else $error("answer to short setup");
  chk_setup_taken: assert property (
    t_su && tok_ok && tok_len == 7'h08 |=> rsp_vld
    && rsp_kind inside {ezcs_pkg::RSP_ACK, ezcs_pkg::RSP_STALL})
    else $error("good setup not handshaken");
  chk_in_answered: assert property (
    tok_vld && tok_kind == ezcs_pkg::TOK_IN
    |=> rsp_vld && rsp_kind != ezcs_pkg::RSP_ACK)
    else $error("in token badly answered");
  chk_out_oversize: assert property (
    t_out && tok_ok && tok_len > MAXP
    |=> rsp_vld && rsp_kind == ezcs_pkg::RSP_STALL)
    else $error("oversize out not stalled");
  chk_out_answered: assert property (
    t_out && tok_ok && tok_len <= MAXP
    |=> rsp_vld && rsp_kind != ezcs_pkg::RSP_DATA)
    else $error("good out badly answered");
endmodule

// ==== verification/endpoint0_control_status_bench.sv ====
// Bench: both link ends joined, each driven as an APB3 slave.
// Assumes one 100 MHz clock; tasks poll for answers, but the monitor expects them one cycle after the token.
`timescale 1ns/10ps
`include "ezcs_map.svh"
module endpoint0_control_status_bench;
  localparam int        MAXP = `EZCS_MAXP;
  localparam logic      D    = 1'b0;
  localparam logic      H    = 1'b1;
  localparam logic [11:0] CSR = 12'(`EZCS_IDX_CSR) << 2;
  localparam logic [11:0] CNT = 12'(`EZCS_IDX_CNT) << 2;
  localparam logic [11:0] TXL = 12'(`EZCS_IDX_TXLEN) << 2;
  localparam logic [11:0] IST = 12'(`EZCS_IDX_IRQ_STAT) << 2;
  localparam logic [11:0] IMK = 12'(`EZCS_IDX_IRQ_MASK) << 2;
  logic        clk_i    = 1'b0;
  logic        resetn_i = 1'b0;
  logic        psel_d   = 1'b0;
  logic        psel_h   = 1'b0;
  logic        penable  = 1'b0;
  logic        pwrite   = 1'b0;
  logic [11:0] paddr    = '0;
  logic [31:0] pwdata   = '0;
  logic [31:0] rdata_d, rdata_h, rd;
  logic        rdy_d, rdy_h, err_d, err_h, irq_d, irq_h, err;
  logic [8:0]  w_rsp    = '0;
  int          n_rsp    = 0;
  int          fails    = 0;
  int          num_checks = 0;
  int          cycles   = 0;
  ezcs_if lnk ();
  always #5 clk_i = ~clk_i;

  ezcs_dev #(.MAXP(MAXP)) i_ezcs_dev (.clk_i(clk_i), .resetn_i(resetn_i),
    .psel_i(psel_d), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
    .pwdata_i(pwdata), .prdata_o(rdata_d), .pready_o(rdy_d),
    .pslverr_o(err_d), .irq_o(irq_d), .link(lnk.dev));
  ezcs_host #(.TIMEOUT(16)) i_ezcs_host (.clk_i(clk_i), .resetn_i(resetn_i),
    .psel_i(psel_h), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
    .pwdata_i(pwdata), .prdata_o(rdata_h), .pready_o(rdy_h),
    .pslverr_o(err_h), .irq_o(irq_h), .link(lnk.host));
  ezcs_monitor #(.MAXP(MAXP)) i_ezcs_monitor (.clk_i(clk_i),
    .resetn_i(resetn_i), .tok_vld(lnk.tok_vld), .tok_kind(lnk.tok_kind),
    .tok_len(lnk.tok_len), .tok_ok(lnk.tok_ok), .rsp_vld(lnk.rsp_vld),
    .rsp_kind(lnk.rsp_kind), .rsp_len(lnk.rsp_len));

  // Wire-side record of every answer, sampled mid-cycle where it is settled
  always @(negedge clk_i) begin
    if (lnk.rsp_vld === 1'b1) begin
      w_rsp <= {lnk.rsp_len, lnk.rsp_kind};
      n_rsp <= n_rsp + 1;
    end
  end

  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      fails++;
      complete_run();
    end
  end

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic apb(input logic h, input logic w, input logic [11:0] a,
                     input logic [31:0] wd);
    @(posedge clk_i);
    psel_d  <= ~h;
    psel_h  <= h;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge clk_i);
    penable <= 1'b1;
    // Ready is judged just before the edge that samples it, never at it
    do @(negedge clk_i); while ((h ? rdy_h : rdy_d) !== 1'b1);
    rd  = h ? rdata_h : rdata_d;
    err = h ? err_h : err_d;
    @(posedge clk_i);
    psel_d  <= 1'b0;
    psel_h  <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdc(input logic [11:0] a, input string nm,
                     input logic [31:0] e);
    apb(D, 1'b0, a, '0);
    chk(nm, e, rd);
  endtask

  // Host command; except for ACK, waits on the host busy flag, leaving its status in rd
  task automatic tok(input ezcs_pkg::ezcs_tok_t k, input logic [6:0] n,
                     input logic ok);
    apb(H, 1'b1, `EZCS_H_CMD, {22'h0, ok, n, k});
    if (k != ezcs_pkg::TOK_ACK)
      do apb(H, 1'b0, `EZCS_H_STAT, '0); while (rd[0] !== 1'b0);
  endtask

  task automatic rsp(input ezcs_pkg::ezcs_rsp_t k);
    chk("host rsp kind", {30'h0, k}, {30'h0, rd[3:2]});
    chk("wire rsp kind", {30'h0, k}, {30'h0, w_rsp[1:0]});
  endtask

  task automatic dlen(input logic [6:0] n);
    chk("host rsp len", {25'h0, n}, {25'h0, rd[10:4]});
    chk("wire rsp len", {25'h0, n}, {25'h0, w_rsp[8:2]});
  endtask

  // Two falling edges let a register write and the irq flop both land
  task automatic irqc(input logic e);
    repeat (2) @(negedge clk_i);
    chk("irq_o", {31'h0, e}, {31'h0, irq_d});
  endtask

  initial begin
    repeat (16) @(posedge clk_i);
    resetn_i <= 1'b1;
    rdc(CSR, "csr reset", 32'h00);
    rdc(IMK, "mask reset", 32'h00);
    apb(D, 1'b0, 12'hC44, '0);
    chk("unmapped err", 32'h1, {31'h0, err});
    chk("unmapped data", 32'h0, rd);
    apb(D, 1'b1, IMK, 32'h0F);
    apb(H, 1'b1, `EZCS_H_IRQ_MASK, 32'h2);
    tok(ezcs_pkg::TOK_SETUP, 7'h08, 1'b1);
    rsp(ezcs_pkg::RSP_ACK);
    chk("host irq idle", 32'h0, {31'h0, irq_h});
    irqc(1'b1);
    rdc(CSR, "csr rx", 32'h01);
    rdc(CNT, "rx count", 32'h08);
    rdc(IST, "irq stat rx", 32'h01);
    irqc(1'b0);
    apb(D, 1'b1, CSR, 32'h00);
    apb(D, 1'b1, CSR, 32'h01);
    rdc(CSR, "csr ro kept", 32'h01);
    apb(D, 1'b1, CSR, 32'h40);
    rdc(CSR, "csr out ack", 32'h00);
    rdc(CNT, "count stale", 32'h00);
    tok(ezcs_pkg::TOK_OUT, 7'h04, 1'b0);
    chk("host timed out", 32'h1, {31'h0, rd[1]});
    chk("host irq", 32'h1, {31'h0, irq_h});
    apb(H, 1'b0, `EZCS_H_IRQ_STAT, '0);
    chk("host irq stat", 32'h3, rd);
    tok(ezcs_pkg::TOK_SETUP, 7'h05, 1'b1);
    rdc(CSR, "no rx", 32'h00);
    chk("wire answers", 32'h1, n_rsp);
    tok(ezcs_pkg::TOK_IN, 7'h00, 1'b1);
    rsp(ezcs_pkg::RSP_NAK);
    apb(D, 1'b1, TXL, 32'h03);
    apb(D, 1'b1, CSR, 32'h02);
    tok(ezcs_pkg::TOK_IN, 7'h00, 1'b1);
    rsp(ezcs_pkg::RSP_DATA);
    dlen(7'h03);
    rdc(CSR, "tx pending", 32'h02);
    tok(ezcs_pkg::TOK_ACK, 7'h00, 1'b1);
    rdc(CSR, "tx done", 32'h00);
    rdc(IST, "tx irq", 32'h02);
    apb(D, 1'b1, CSR, 32'h02);
    tok(ezcs_pkg::TOK_SETUP, 7'h08, 1'b1);
    rdc(CSR, "overwritten", 32'h11);
    rdc(IST, "overwrite irq", 32'h0B);
    apb(D, 1'b1, CSR, 32'h80);
    rdc(CSR, "setup end ack", 32'h01);
    apb(D, 1'b1, CSR, 32'h40);
    apb(D, 1'b1, CSR, 32'h20);
    rdc(CSR, "stall armed", 32'h20);
    tok(ezcs_pkg::TOK_OUT, 7'h04, 1'b1);
    rsp(ezcs_pkg::RSP_STALL);
    rdc(CSR, "stall sent", 32'h04);
    rdc(IST, "stall irq", 32'h04);
    apb(D, 1'b1, CSR, 32'h04);
    rdc(CSR, "stall kept", 32'h04);
    apb(D, 1'b1, CSR, 32'h00);
    rdc(CSR, "stall cleared", 32'h00);
    tok(ezcs_pkg::TOK_OUT, 7'(MAXP + 1), 1'b1);
    rsp(ezcs_pkg::RSP_STALL);
    rdc(CSR, "oversize", 32'h04);
    apb(D, 1'b1, CSR, 32'h0E);
    tok(ezcs_pkg::TOK_IN, 7'h00, 1'b1);
    dlen(7'h03);
    tok(ezcs_pkg::TOK_ACK, 7'h00, 1'b1);
    rdc(CSR, "last cleared", 32'h04);
    apb(D, 1'b1, CSR, 32'h0C);
    tok(ezcs_pkg::TOK_IN, 7'h00, 1'b1);
    rsp(ezcs_pkg::RSP_DATA);
    dlen(7'h00);
    tok(ezcs_pkg::TOK_ACK, 7'h00, 1'b1);
    rdc(CSR, "zlp done", 32'h04);
    apb(D, 1'b0, IST, '0);
    apb(D, 1'b1, IMK, 32'h00);
    tok(ezcs_pkg::TOK_SETUP, 7'h08, 1'b1);
    irqc(1'b0);
    apb(D, 1'b1, IMK, 32'h0F);
    irqc(1'b1);
    complete_run();
  end
endmodule
